// file: pcie_msg_port_defs.vh
// constants for the sideband message port
`ifndef PCIE_MSG_PORT_DEFS_VH
`define PCIE_MSG_PORT_DEFS_VH
// transmit message type codes
`define TX_TYPE_LTR 3'h0
`define TX_TYPE_OBFF 3'h1
`define TX_TYPE_SSPL 3'h2
`define TX_TYPE_PME 3'h3
// ltr field positions
`define LTR_SNOOP_REQ 31
`define LTR_SNOOP_SCALE 28:26
`define LTR_SNOOP_VALUE 25:16
`define LTR_NOSNOOP_REQ 15
`define LTR_NOSNOOP_SCALE 12:10
`define LTR_NOSNOOP_VALUE 9:0
// obff, slot power and pme field positions
`define OBFF_CODE 3:0
`define SSPL_SCALE 9:8
`define SSPL_VALUE 7:0
`define PME_PF 1:0
`define PME_VF 9:4
// reset values
`define RX_TYPE_RST 5'h00
`define RX_DATA_RST 8'h00
`define TX_DATA_RST 32'h0000_0000
`endif

// file: pcie_cfg_message_port.v
// sideband message port: received-message delivery and transmit request handshake
`timescale 1ns/1ps
`default_nettype none
`include "pcie_msg_port_defs.vh"
module pcie_cfg_message_port (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// configuration strap, caught after reset release
	input wire rx_message_port_enable_attr,
	// decoded messages from the link, one parameter byte per beat
	input wire lrx_valid,
	input wire [4:0] lrx_type,
	input wire [7:0] lrx_byte,
	input wire lrx_last,
	output wire lrx_ready,
	// received-message port to user logic
	output reg msg_received_q,
	output reg [4:0] msg_received_type_q,
	output reg [7:0] msg_received_data_q,
	// transmit request from user logic
	input wire msg_transmit,
	input wire [2:0] msg_transmit_type,
	input wire [31:0] msg_transmit_data,
	output wire msg_transmit_done,
	// message request to the link transmit engine
	output wire ltx_valid,
	output reg [2:0] ltx_type_q,
	output reg [31:0] ltx_data_q,
	input wire ltx_ready,
	input wire ltx_complete,
	// decoded transmit fields
	output wire ltx_snoop_req,
	output wire [2:0] ltx_snoop_scale,
	output wire [9:0] ltx_snoop_value,
	output wire ltx_nosnoop_req,
	output wire [2:0] ltx_nosnoop_scale,
	output wire [9:0] ltx_nosnoop_value,
	output wire [3:0] ltx_obff_code,
	output wire [1:0] ltx_sspl_scale,
	output wire [7:0] ltx_sspl_value,
	output wire [1:0] ltx_pme_pf,
	output wire [5:0] ltx_pme_vf
);

	// receive delivery states
	localparam RX_IDLE = 2'h0; // waiting for the first beat
	localparam RX_BUSY = 2'h1; // inside a message, beats back to back
	localparam RX_GAP = 2'h2; // forced low cycle after the last beat

	// transmit request states
	localparam TX_IDLE = 3'h0; // no request held
	localparam TX_ISSUE = 3'h1; // offering the message to the engine
	localparam TX_WAIT = 3'h2; // engine busy sending
	localparam TX_DONE = 3'h3; // done pulse cycle
	localparam TX_DROP = 3'h4; // waiting for the user to let go

	// strap capture
	reg en_q;
	reg cap_done_q;

	// state registers
	reg [1:0] rx_state_q;
	reg [2:0] tx_state_q;

	// a beat is taken only while enabled and not in the gap
	wire rx_take;

	// strap caught once after release; reset itself only loads constants
	// the setting is fixed at configuration time, so one look is enough
	// and a pin that wanders later cannot cut a message in half
	always @(posedge clk) begin
		if (sys_rst) begin
			en_q <= 1'b0;
			cap_done_q <= 1'b0;
		end else if (!cap_done_q) begin
			en_q <= rx_message_port_enable_attr;
			cap_done_q <= 1'b1;
		end
	end

	// when disabled, beats are swallowed so the decoder never stalls
	// a refused beat must be held by the decoder until ready returns
	assign lrx_ready = !en_q || (rx_state_q != RX_GAP);
	assign rx_take = lrx_valid && lrx_ready && en_q;

	// receive delivery: one byte per high cycle, forced gap after last beat
	// type and byte only move on a taken beat, so they stay put while low
	// the per-type beat count is left to the decoder through lrx_last
	always @(posedge clk) begin
		if (sys_rst) begin
			rx_state_q <= RX_IDLE;
			msg_received_q <= 1'b0;
			msg_received_type_q <= `RX_TYPE_RST;
			msg_received_data_q <= `RX_DATA_RST;
		end else begin
			case (rx_state_q)
				// idle or inside a message: take the next beat if offered
				// a missing beat inside a message closes it early
				RX_IDLE, RX_BUSY: begin
					msg_received_q <= rx_take;
					if (rx_take) begin
						msg_received_type_q <= lrx_type;
						msg_received_data_q <= lrx_byte;
						rx_state_q <= lrx_last ? RX_GAP : RX_BUSY;
					end else if (rx_state_q == RX_BUSY) begin
						// a stalled stream still ends with a low cycle
						rx_state_q <= RX_GAP;
						msg_received_q <= 1'b0;
					end
				end

				// gap cycle: indication low, decoder held off by ready
				RX_GAP: begin
					msg_received_q <= 1'b0;
					rx_state_q <= RX_IDLE;
				end

				// unused code: fall back to idle with the indication low
				default: begin
					msg_received_q <= 1'b0;
					rx_state_q <= RX_IDLE;
				end
			endcase
		end
	end

	// transmit sequencing; request is captured so later input changes are harmless
	// the user request is only looked at in idle and drop, so a request held
	// past done is never taken twice
	always @(posedge clk) begin
		if (sys_rst) begin
			tx_state_q <= TX_IDLE;
			ltx_type_q <= `TX_TYPE_LTR;
			ltx_data_q <= `TX_DATA_RST;
		end else begin
			case (tx_state_q)
				// idle: capture type and data on a new request
				TX_IDLE: begin
					if (msg_transmit) begin
						ltx_type_q <= msg_transmit_type;
						ltx_data_q <= msg_transmit_data;
						// reserved codes are answered without sending anything
						tx_state_q <= msg_transmit_type[2] ? TX_DONE : TX_ISSUE;
					end
				end

				// offer: held until the engine takes it
				// the engine may keep ready low for any number of cycles
				TX_ISSUE: begin
					if (ltx_ready)
						tx_state_q <= TX_WAIT;
				end

				// engine sending: wait for its completion pulse
				// no time limit here, so a lost completion stalls the port
				TX_WAIT: begin
					if (ltx_complete)
						tx_state_q <= TX_DONE;
				end

				// done stands one cycle only
				TX_DONE: begin
					tx_state_q <= TX_DROP;
				end

				// drop: wait for the request to go low
				TX_DROP: begin
					// a held request after done must not start a second send
					if (!msg_transmit)
						tx_state_q <= TX_IDLE;
				end

				// unused codes: back to idle
				default: begin
					tx_state_q <= TX_IDLE;
				end
			endcase
		end
	end

	// engine offer and done are decoded from state, no extra flops
	// both change only on the edge that moves the state register
	assign ltx_valid = (tx_state_q == TX_ISSUE);
	assign msg_transmit_done = (tx_state_q == TX_DONE);

	// field decode of the captured data word
	// slices stay valid from one take until the next

	// ltr fields: snoop half in the upper word, no-snoop half in the lower
	assign ltx_snoop_req = ltx_data_q[`LTR_SNOOP_REQ];
	assign ltx_snoop_scale = ltx_data_q[`LTR_SNOOP_SCALE];
	assign ltx_snoop_value = ltx_data_q[`LTR_SNOOP_VALUE];
	assign ltx_nosnoop_req = ltx_data_q[`LTR_NOSNOOP_REQ];
	assign ltx_nosnoop_scale = ltx_data_q[`LTR_NOSNOOP_SCALE];
	assign ltx_nosnoop_value = ltx_data_q[`LTR_NOSNOOP_VALUE];

	// obff code in the low nibble
	assign ltx_obff_code = ltx_data_q[`OBFF_CODE];

	// slot power: scale above value in the low ten bits
	assign ltx_sspl_scale = ltx_data_q[`SSPL_SCALE];
	assign ltx_sspl_value = ltx_data_q[`SSPL_VALUE];

	// pme flags: physical functions low, virtual functions above a gap
	assign ltx_pme_pf = ltx_data_q[`PME_PF];
	assign ltx_pme_vf = ltx_data_q[`PME_VF];

endmodule
`default_nettype wire

// file: mp_chk_assertions.sv
// checker for the message port
`timescale 1ns/1ps
`default_nettype none
module mp_chk(input wire clk, input wire sys_rst, input wire lrx_valid, input wire [4:0] lrx_type,
	input wire [7:0] lrx_byte, input wire lrx_ready, input wire msg_received_q,
	input wire [4:0] msg_received_type_q, input wire [7:0] msg_received_data_q,
	input wire [31:0] msg_transmit_data, input wire msg_transmit_done, input wire ltx_valid,
	input wire [2:0] ltx_type_q, input wire [31:0] ltx_data_q, input wire ltx_ready,
	input wire ltx_complete, input wire [3:0] ltx_obff_code, input wire [5:0] ltx_pme_vf);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_last; msg_received_q && !lrx_ready; endsequence
	sequence s_beat; lrx_valid && lrx_ready && msg_received_q; endsequence
	a_msg_gap: assert property (s_last |=> !msg_received_q) else $error("no gap");
	a_beat_out: assert property (s_beat |=> msg_received_q && msg_received_data_q == $past(lrx_byte)
		&& msg_received_type_q == $past(lrx_type)) else $error("beat");
	a_done_pulse: assert property (msg_transmit_done |=> !msg_transmit_done) else $error("pulse");
	a_done_cause: assert property (ltx_complete |=> msg_transmit_done) else $error("done");
	a_valid_hold: assert property (ltx_valid && !ltx_ready |=> ltx_valid) else $error("hold");
	a_take_data: assert property ($rose(ltx_valid) |-> ltx_data_q == $past(msg_transmit_data))
		else $error("take");
	a_no_rsv: assert property (ltx_valid |-> !ltx_type_q[2]) else $error("rsv");
	a_field_map: assert property ($rose(ltx_valid) |-> ltx_obff_code == $past(msg_transmit_data[3:0])
		&& ltx_pme_vf == $past(msg_transmit_data[9:4])) else $error("field");
endmodule
bind pcie_cfg_message_port mp_chk u_chk (.*);
`default_nettype wire

// file: user_req_model.sv
// user-side transmit requester model
`timescale 1ns/1ps
`default_nettype none
module user_req_model(input wire logic clk, input wire logic sys_rst, input wire logic go,
	input wire logic [2:0] ty, input wire logic [31:0] dt, input wire logic done,
	output logic req = 1'b0, output logic [2:0] rt = 3'h0, output logic [31:0] rd = 32'h0);
	// request held until done; released data toggles so it is never stale
	always @(posedge clk) begin
		if (sys_rst || done) req <= 1'b0;
		else if (go && !req) begin
			req <= 1'b1;
			rt <= ty;
			rd <= dt;
		end else if (!req) rd <= ~rd;
	end
endmodule
`default_nettype wire

// file: pcie_cfg_message_port_tb.sv
// random bench for the message port
`timescale 1ns/1ps
`default_nettype none
module pcie_cfg_message_port_tb;
	logic clk, sys_rst, en, run, go, mt, done, lv, lr, ll, lxv, lxr, lxc, rq;
	logic [4:0] lt, rty;
	logic [7:0] lb, rd8;
	logic [2:0] ty, rt, xt;
	logic [31:0] dt, rd, xd, r, seed;
	logic [27:0] xf;
	logic [9:0] sv;
	logic [3:0] oc;
	logic [1:0] pf;
	logic [5:0] vf;
	logic [13:0] e, q[$];
	int n_errors = 0, cmp_count = 0, nr = 0, nd = 0;
	pcie_cfg_message_port u_dut(.clk(clk), .sys_rst(sys_rst), .rx_message_port_enable_attr(en),
		.lrx_valid(lv), .lrx_type(lt), .lrx_byte(lb), .lrx_last(ll), .lrx_ready(lr),
		.msg_received_q(rq), .msg_received_type_q(rty), .msg_received_data_q(rd8),
		.msg_transmit(mt), .msg_transmit_type(rt), .msg_transmit_data(rd), .msg_transmit_done(done),
		.ltx_valid(lxv), .ltx_type_q(xt), .ltx_data_q(xd), .ltx_ready(lxr), .ltx_complete(lxc),
		.ltx_snoop_req(xf[27]), .ltx_snoop_scale(xf[26:24]), .ltx_snoop_value(sv),
		.ltx_nosnoop_req(xf[23]), .ltx_nosnoop_scale(xf[22:20]), .ltx_nosnoop_value(xf[19:10]),
		.ltx_obff_code(oc), .ltx_sspl_scale(xf[9:8]), .ltx_sspl_value(xf[7:0]), .ltx_pme_pf(pf),
		.ltx_pme_vf(vf));
	user_req_model u_user(.clk(clk), .sys_rst(sys_rst), .go(go), .ty(ty), .dt(dt), .done(done),
		.req(mt), .rt(rt), .rd(rd));
	function automatic [27:0] fx(input [31:0] d);
		fx = {d[31], d[28:26], d[15], d[12:10], d[9:0], d[9:8], d[7:0]};
	endfunction
	function automatic [21:0] fy(input [31:0] d);
		fy = {d[25:16], d[3:0], d[1:0], d[9:4]};
	endfunction
	task chk(input string n, input [63:0] x, input [63:0] s);
		cmp_count++;
		if (x !== s) begin
			n_errors++;
			$display("wrong value %s exp %h got %h", n, x, s);
		end
	endtask
	task finish_test;
		if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// random beats and requests, engine answers, scoreboard
	always @(posedge clk) begin
		r = $random(seed);
		if (!lv || lr) {lv, ll, lt, lb} <= {run & r[0], r[1], r[6:2], r[14:7]};
		go <= run & r[16] & r[17];
		ty <= r[18] & r[21] ? 3'h4 | r[20:19] : {1'b0, r[20:19]};
		dt <= r[22] ? 32'hffff_ffff : $random(seed);
		if (rq) begin
			e = q.size() ? q.pop_front() : 14'h0;
			chk("rx", e, {1'b1, rty, rd8});
		end
		if (!sys_rst && en && lv && lr) q.push_back({1'b1, lt, lb});
		if (done) nd++;
		if (done) chk("tx", {rt, rd, fx(rd)}, {xt, xd, xf});
		if (done) chk("fld", fy(rd), {sv, oc, pf, vf});
		if (!sys_rst && go && !mt && !done) nr++;
		lxr <= lxv && !lxr;
		lxc <= lxr;
	end
	// first pass disabled, second pass enabled after a second reset
	initial begin
		seed = 32'h9011;
		{sys_rst, en, run, go, lv, ll, lt, lb, lxr, lxc, ty, dt} = {1'b1, 55'h0};
		repeat (2) begin
			repeat (16) @(posedge clk);
			sys_rst <= 1'b0;
			repeat (4) @(posedge clk);
			run <= 1'b1;
			repeat (1000) @(posedge clk);
			run <= 1'b0;
			repeat (20) @(posedge clk);
			sys_rst <= 1'b1;
			en <= 1'b1;
		end
		chk("count", nr, nd);
		chk("left", 0, q.size());
		finish_test;
	end
	initial begin
		#120000;
		n_errors++;
		finish_test;
	end
endmodule
`default_nettype wire
